// [verilog/fp_special_pkg.sv]
// Types and constants for nonnormal and zero operand handling
//Operation
// - Short denormal store: round 24, drop integer, +126
// - Any fetched denormal operand raises denormal; here a denormal divisor or transcendental operand does not
// - Loaded short/long denormal becomes equivalent unnormal
// - Arithmetic/compare convert denormal operand, then proceed
// - Denormal divisor in divide/remainder gives invalid
// - Unnormal: temp only, integer bit 0, tagged valid
// - Add/sub normalization follows larger-magnitude operand
// - Multiply with any unnormal operand gives unnormal
// - Divide with only dividend unnormal gives unnormal
// - Remainder with only dividend unnormal gives normalized
// - Compare/test normalize unnormals as far as possible
// - Round to integer normalizes unnormal operand first
// - Unnormal store short/long: invalid above boundary, else underflow
// - Transcendentals check nothing; non-normal operands undefined
// - True zero in register is tagged zero
// - Integer zero positive; signed real zeros compare equal
// - Pseudo-zero: unnormal, zero significand, exponent not 0/ones
// - Unnormal product with over 64 leading zeros: pseudo-zero
// - Opposite zeros or equal opposites sum to rounding-signed zero
// - Remainder of zero by nonzero keeps dividend sign
// - Rounding-signed zero: negative only for round down
// - Denormal and zero share exponent 0; denormal tagged special
package fp_special_pkg;

    localparam logic [14:0] EXP_ONES = 15'h7FFF;
    localparam logic [14:0] EXP_BIAS_T = 15'h3FFF;
    localparam logic [14:0] SHORT_MIN_EXP = 15'h3F81;
    localparam logic [14:0] LONG_MIN_EXP = 15'h3C01;
    localparam logic [14:0] SHORT_TO_T = 15'h3F80;
    localparam logic [14:0] LONG_TO_T = 15'h3C00;
    localparam logic [14:0] TEMP_DEN_EXP = 15'h0001;
    localparam logic [63:0] INDEF_SIG = 64'hC000_0000_0000_0000;
    localparam logic [7:0] PSEUDO_ZERO_LZ = 8'h40;
    localparam int SHORT_RND_BITS = 24;
    localparam int LONG_RND_BITS = 53;

    typedef enum logic [1:0] {FMT_SHORT = 2'h0, FMT_LONG = 2'h1, FMT_TEMP = 2'h2} fmt_e;
    typedef enum logic [1:0] {RC_NEAREST = 2'h0, RC_DOWN = 2'h1, RC_UP = 2'h2, RC_CHOP = 2'h3} rnd_e;
    typedef enum logic [1:0] {TAG_VALID = 2'h0, TAG_ZERO = 2'h1, TAG_SPECIAL = 2'h2, TAG_EMPTY = 2'h3} tag_e;
    typedef enum logic [1:0] {CC_GREATER = 2'h0, CC_LESS = 2'h1, CC_EQUAL = 2'h2} cc_e;
    typedef enum logic [4:0] {
        OP_LOAD_REAL = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_MUL = 5'h03,
        OP_DIV = 5'h04, OP_PARTIAL_REMAINDER = 5'h05, OP_COMPARE = 5'h06,
        OP_TEST_AGAINST_ZERO = 5'h07, OP_ROUND_TO_INTEGER = 5'h08, OP_SQUARE_ROOT = 5'h09,
        OP_STORE_REAL = 5'h0A, OP_STORE_REAL_AND_POP = 5'h0B, OP_STORE_INTEGER = 5'h0C,
        OP_STORE_INTEGER_AND_POP = 5'h0D, OP_STORE_PACKED_DECIMAL_AND_POP = 5'h0E,
        OP_EXCHANGE_REGISTERS = 5'h0F, OP_EXAMINE_OPERAND = 5'h10, OP_TRANSCENDENTAL = 5'h11
    } op_e;

    typedef struct packed {
        logic sign;
        logic [14:0] exp;
        logic [63:0] sig;
    } treal_s;

    typedef struct packed {
        fmt_e fmt;
        logic [79:0] bits;
    } opnd_s;

    typedef struct packed {
        logic denormal;
        logic invalid;
        logic underflow;
    } exc_s;

    typedef struct packed {
        logic zero;
        logic denormal;
        logic unnormal;
        logic pseudo_zero;
        logic [6:0] lz;
    } info_s;

    typedef struct packed {
        logic handled;
        logic unnormal_res;
        tag_e tag;
        cc_e cc;
    } stat_s;

endpackage

// [verilog/opnd_unpack.sv]
// Operand unpacker: memory format to temporary real plus class
`timescale 1ns/1ps
`default_nettype none
module opnd_unpack
    import fp_special_pkg::*;
(
    // Raw operand
    input wire opnd_s opnd_i,
    // Temporary real form and class
    output treal_s val_o,
    output info_s info_o
);

    // Widen, turn denormals into equivalent unnormals, classify
    always_comb begin
        val_o = '0;
        info_o = '0;
        unique case (opnd_i.fmt)
            FMT_SHORT: begin
                val_o.sign = opnd_i.bits[31];
                val_o.sig = {1'b1, opnd_i.bits[22:0], 40'h0};
                if (opnd_i.bits[30:23] == 8'h00) begin
                    info_o.denormal = opnd_i.bits[22:0] != 23'h0;
                    val_o.sig[63] = 1'b0;
                    val_o.exp = info_o.denormal ? SHORT_MIN_EXP : 15'h0;
                end else if (opnd_i.bits[30:23] == 8'hFF) begin
                    val_o.exp = EXP_ONES;
                end else begin
                    val_o.exp = {7'h0, opnd_i.bits[30:23]} + SHORT_TO_T;
                end
            end
            FMT_LONG: begin
                val_o.sign = opnd_i.bits[63];
                val_o.sig = {1'b1, opnd_i.bits[51:0], 11'h0};
                if (opnd_i.bits[62:52] == 11'h000) begin
                    info_o.denormal = opnd_i.bits[51:0] != 52'h0;
                    val_o.sig[63] = 1'b0;
                    val_o.exp = info_o.denormal ? LONG_MIN_EXP : 15'h0;
                end else if (opnd_i.bits[62:52] == 11'h7FF) begin
                    val_o.exp = EXP_ONES;
                end else begin
                    val_o.exp = {4'h0, opnd_i.bits[62:52]} + LONG_TO_T;
                end
            end
            default: begin
                val_o = opnd_i.bits;
                info_o.denormal = (val_o.exp == 15'h0) && (val_o.sig != 64'h0);
                if (info_o.denormal) begin
                    val_o.exp = TEMP_DEN_EXP;
                end
            end
        endcase
        info_o.zero = (val_o.exp == 15'h0) && (val_o.sig == 64'h0);
        info_o.unnormal = (val_o.exp != 15'h0) && (val_o.exp != EXP_ONES) && !val_o.sig[63];
        info_o.pseudo_zero = info_o.unnormal && (val_o.sig == 64'h0);
        info_o.lz = 7'h40;
        for (int i = 0; i < 64; i++) begin
            if (val_o.sig[i]) begin
                info_o.lz = 7'(63 - i);
            end
        end
    end

endmodule
`default_nettype wire

// [verilog/store_denorm.sv]
// Gradual underflow for short and long real stores
`timescale 1ns/1ps
`default_nettype none
module store_denorm
    import fp_special_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Request
    input wire logic start_i,
    input wire treal_s val_i,
    input wire fmt_e fmt_i,
    input wire rnd_e rc_i,
    // Result
    output logic done_o,
    output logic [63:0] bits_o
);

    typedef enum logic [1:0] {DN_IDLE = 2'h0, DN_SHIFT = 2'h1, DN_ROUND = 2'h3} dn_state_e;

    dn_state_e state_r;
    logic sign_r;
    logic [14:0] exp_r;
    logic [14:0] min_r;
    logic [63:0] sig_r;
    logic sticky_r;
    fmt_e fmt_r;
    rnd_e rc_r;
    logic [52:0] kept;
    logic rbit;
    logic rest;
    logic inc;
    logic [52:0] rounded;

    // Sequencing
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r <= DN_IDLE;
        end else begin
            unique case (state_r)
                DN_IDLE: if (start_i) state_r <= DN_SHIFT;
                DN_SHIFT: if (exp_r >= min_r) state_r <= DN_ROUND;
                DN_ROUND: state_r <= DN_IDLE;
            endcase
        end
    end

    // One exponent step and one right shift per cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sign_r <= 1'b0;
            exp_r <= 15'h0;
            min_r <= SHORT_MIN_EXP;
            sig_r <= 64'h0;
            sticky_r <= 1'b0;
            fmt_r <= FMT_SHORT;
            rc_r <= RC_NEAREST;
        end else if (state_r == DN_IDLE && start_i) begin
            sign_r <= val_i.sign;
            exp_r <= val_i.exp;
            min_r <= (fmt_i == FMT_LONG) ? LONG_MIN_EXP : SHORT_MIN_EXP;
            sig_r <= val_i.sig;
            sticky_r <= 1'b0;
            fmt_r <= fmt_i;
            rc_r <= rc_i;
        end else if (state_r == DN_SHIFT && exp_r < min_r) begin
            exp_r <= exp_r + 15'h1;
            sig_r <= {1'b0, sig_r[63:1]};
            sticky_r <= sticky_r | sig_r[0];
        end
    end

    // Round to destination width under the rounding mode
    always_comb begin
        if (fmt_r == FMT_LONG) begin
            kept = sig_r[63 -: LONG_RND_BITS];
            rbit = sig_r[10];
            rest = (sig_r[9:0] != 10'h0) | sticky_r;
        end else begin
            kept = {29'h0, sig_r[63 -: SHORT_RND_BITS]};
            rbit = sig_r[39];
            rest = (sig_r[38:0] != 39'h0) | sticky_r;
        end
        unique case (rc_r)
            RC_NEAREST: inc = rbit & (rest | kept[0]);
            RC_UP: inc = (rbit | rest) & !sign_r;
            RC_DOWN: inc = (rbit | rest) & sign_r;
            RC_CHOP: inc = 1'b0;
        endcase
        rounded = kept + {52'h0, inc};
    end

    // Pack: integer bit dropped, exponent field is 0 or 1 after carry
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
            bits_o <= 64'h0;
        end else begin
            done_o <= state_r == DN_ROUND;
            if (state_r == DN_ROUND) begin
                if (fmt_r == FMT_LONG) begin
                    bits_o <= {sign_r, 10'h0, rounded[52], rounded[51:0]};
                end else begin
                    bits_o <= {32'h0, sign_r, 7'h0, rounded[23], rounded[22:0]};
                end
            end
        end
    end

endmodule
`default_nettype wire

// [verilog/fp_special_handler.sv]
// Special operand handler: nonnormal, pseudo-zero and zero cases
`timescale 1ns/1ps
`default_nettype none
module fp_special_handler
    import fp_special_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Operation request
    input wire logic start_i,
    input wire op_e op_i,
    input wire opnd_s opa_i,
    input wire opnd_s opb_i,
    input wire fmt_e dst_fmt_i,
    // Control word
    input wire rnd_e rc_i,
    input wire exc_s mask_i,
    // Answer
    output logic done_o,
    output logic dest_we_o,
    output treal_s res_o,
    output logic [63:0] mem_o,
    output stat_s stat_o,
    output exc_s exc_o,
    output logic int_req_o,
    // Prepared operands for the arithmetic core
    output treal_s opa_o,
    output treal_s opb_o
);

    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_EVAL = 2'h1, ST_DENORM = 2'h3} state_e;

    localparam treal_s INDEF = '{sign: 1'b1, exp: EXP_ONES, sig: INDEF_SIG};

    state_e state_r;
    op_e op_r;
    opnd_s a_r;
    opnd_s b_r;
    fmt_e dst_r;
    rnd_e rc_r;
    exc_s mask_r;
    treal_s ua;
    treal_s ub;
    info_s ia;
    info_s ib;
    treal_s na;
    treal_s nb;
    treal_s ev_res;
    treal_s ev_opa;
    treal_s ev_opb;
    exc_s ev_exc;
    logic ev_handled;
    logic ev_unn;
    logic ev_write;
    logic ev_den_go;
    cc_e ev_cc;
    logic bsign;
    logic zsign;
    logic above;
    logic stop;
    logic [16:0] pexp;
    logic dn_done;
    logic [63:0] dn_bits;

    // Bring a value to its normal form as far as the exponent allows
    function automatic treal_s norm_f(input treal_s v, input logic [6:0] lz);
        treal_s n;
        logic [14:0] sh;
        n = v;
        sh = {8'h0, lz};
        if (v.exp != 15'h0 && v.exp != EXP_ONES && !v.sig[63]) begin
            if (sh > v.exp - 15'h1) begin
                sh = v.exp - 15'h1;
            end
            n.exp = v.exp - sh;
            n.sig = (sh > 15'h3F) ? 64'h0 : (v.sig << sh);
        end
        return n;
    endfunction

    // Magnitude key, zero significand counts as nothing
    function automatic logic [78:0] mag_f(input treal_s v);
        return (v.sig == 64'h0) ? 79'h0 : {v.exp, v.sig};
    endfunction

    // Signed compare with one unsigned zero
    function automatic cc_e cmp_f(input treal_s x, input treal_s y);
        logic xs;
        logic ys;
        xs = x.sign && (mag_f(x) != 79'h0);
        ys = y.sign && (mag_f(y) != 79'h0);
        if (mag_f(x) == mag_f(y) && xs == ys) begin
            return CC_EQUAL;
        end else if (xs != ys) begin
            return xs ? CC_LESS : CC_GREATER;
        end else begin
            return ((mag_f(x) > mag_f(y)) ^ xs) ? CC_GREATER : CC_LESS;
        end
    endfunction

    // Register tag of a temporary real value
    function automatic tag_e tag_f(input treal_s v);
        if (v.exp == 15'h0 && v.sig == 64'h0) begin
            return TAG_ZERO;
        end else if (v.exp == 15'h0 || v.exp == EXP_ONES) begin
            return TAG_SPECIAL;
        end else begin
            return TAG_VALID;
        end
    endfunction

    // Operand unpackers
    opnd_unpack u_unpack_a (
        .opnd_i(a_r),
        .val_o(ua),
        .info_o(ia)
    );

    opnd_unpack u_unpack_b (
        .opnd_i(b_r),
        .val_o(ub),
        .info_o(ib)
    );

    // Gradual underflow engine
    store_denorm u_denorm (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .start_i(state_r == ST_EVAL && ev_den_go && !stop),
        .val_i(na),
        .fmt_i(dst_r),
        .rc_i(rc_r),
        .done_o(dn_done),
        .bits_o(dn_bits)
    );

    // Normalized operand copies for compare, test and rounding
    always_comb begin
        na = norm_f(ua, ia.lz);
        nb = norm_f(ub, ib.lz);
    end

    // Decide the special-case outcome of the latched operation
    always_comb begin
        ev_res = ua;
        ev_opa = ua;
        ev_opb = ub;
        ev_exc = '0;
        ev_handled = 1'b0;
        ev_unn = 1'b0;
        ev_write = 1'b1;
        ev_den_go = 1'b0;
        ev_cc = CC_EQUAL;
        bsign = (op_r == OP_SUB) ? !ub.sign : ub.sign;
        zsign = rc_r == RC_DOWN;
        above = na.exp >= ((dst_r == FMT_LONG) ? LONG_MIN_EXP : SHORT_MIN_EXP);
        pexp = {2'h0, ua.exp} + {2'h0, ub.exp} - {2'h0, EXP_BIAS_T};
        if (op_r != OP_TRANSCENDENTAL) begin
            ev_exc.denormal = ia.denormal;
            if (op_r inside {OP_ADD, OP_SUB, OP_MUL, OP_COMPARE}) begin
                ev_exc.denormal = ia.denormal | ib.denormal;
            end
        end
        unique case (op_r)
            OP_LOAD_REAL: begin
                ev_handled = 1'b1;
            end
            OP_ADD, OP_SUB: begin
                ev_opb.sign = bsign;
                if (ia.zero && ib.zero) begin
                    ev_handled = 1'b1;
                    ev_res = '0;
                    ev_res.sign = (ua.sign == bsign) ? ua.sign : zsign;
                end else if (ua.sign != bsign && mag_f(na) == mag_f(nb) && !ia.pseudo_zero && !ib.pseudo_zero) begin
                    ev_handled = 1'b1;
                    ev_res = '0;
                    ev_res.sign = zsign;
                end else begin
                    ev_unn = (mag_f(na) >= mag_f(nb)) ? ia.unnormal : ib.unnormal;
                end
            end
            OP_MUL: begin
                if (ia.zero || ib.zero) begin
                    ev_handled = 1'b1;
                    ev_res = '0;
                    ev_res.sign = ua.sign ^ ub.sign;
                end else begin
                    ev_unn = ia.unnormal | ib.unnormal;
                    if (ia.unnormal && ib.unnormal && ({1'b0, ia.lz} + {1'b0, ib.lz} > PSEUDO_ZERO_LZ)) begin
                        ev_handled = 1'b1;
                        ev_res.sign = ua.sign ^ ub.sign;
                        ev_res.sig = 64'h0;
                        if (pexp[16] || pexp == 17'h0) begin
                            ev_res.exp = 15'h1;
                        end else if (pexp[15] || pexp[14:0] == EXP_ONES) begin
                            ev_res.exp = EXP_ONES - 15'h1;
                        end else begin
                            ev_res.exp = pexp[14:0];
                        end
                    end
                end
            end
            OP_DIV, OP_PARTIAL_REMAINDER: begin
                if (ib.denormal || ib.unnormal) begin
                    ev_exc.invalid = 1'b1;
                end else if (ia.zero && !ib.zero) begin
                    ev_handled = 1'b1;
                    ev_res = '0;
                    ev_res.sign = (op_r == OP_DIV) ? (ua.sign ^ ub.sign) : ua.sign;
                end else if (op_r == OP_DIV) begin
                    ev_unn = ia.unnormal;
                end else begin
                    ev_opa = na;
                end
            end
            OP_COMPARE: begin
                ev_handled = 1'b1;
                ev_write = 1'b0;
                ev_opa = na;
                ev_opb = nb;
                ev_cc = cmp_f(na, nb);
            end
            OP_TEST_AGAINST_ZERO: begin
                ev_handled = 1'b1;
                ev_write = 1'b0;
                ev_opa = na;
                ev_cc = cmp_f(na, '0);
            end
            OP_ROUND_TO_INTEGER: begin
                ev_opa = na;
            end
            OP_SQUARE_ROOT: begin
                if (ia.unnormal) begin
                    ev_exc.invalid = 1'b1;
                end else if (ia.zero) begin
                    ev_handled = 1'b1;
                end
            end
            OP_STORE_REAL, OP_STORE_REAL_AND_POP: begin
                if (dst_r == FMT_TEMP || ia.zero) begin
                    ev_handled = 1'b1;
                end else if (ia.unnormal && above) begin
                    ev_exc.invalid = 1'b1;
                end else if (!above && na.exp != EXP_ONES) begin
                    ev_exc.underflow = 1'b1;
                    ev_den_go = !mask_r.underflow ? 1'b0 : 1'b1;
                end
            end
            OP_STORE_INTEGER, OP_STORE_INTEGER_AND_POP, OP_STORE_PACKED_DECIMAL_AND_POP: begin
                if (ia.unnormal) begin
                    ev_exc.invalid = 1'b1;
                end else if (ia.zero) begin
                    ev_handled = 1'b1;
                    if (op_r != OP_STORE_PACKED_DECIMAL_AND_POP) begin
                        ev_res.sign = 1'b0;
                    end
                end
            end
            OP_EXAMINE_OPERAND: begin
                ev_handled = 1'b1;
                ev_write = 1'b0;
            end
            OP_EXCHANGE_REGISTERS, OP_TRANSCENDENTAL: begin
                ev_handled = 1'b0;
            end
        endcase
        if (ev_exc.invalid) begin
            ev_handled = 1'b1;
            ev_unn = 1'b0;
            ev_res = INDEF;
        end
        stop = (ev_exc & ~mask_r) != 3'h0;
    end

    // Operation sequencing
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: if (start_i) state_r <= ST_EVAL;
                ST_EVAL: state_r <= (ev_den_go && !stop) ? ST_DENORM : ST_IDLE;
                ST_DENORM: if (dn_done) state_r <= ST_IDLE;
            endcase
        end
    end

    // Request capture
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            op_r <= OP_LOAD_REAL;
            a_r <= '0;
            b_r <= '0;
            dst_r <= FMT_TEMP;
            rc_r <= RC_NEAREST;
            mask_r <= '0;
        end else if (state_r == ST_IDLE && start_i) begin
            op_r <= op_i;
            a_r <= opa_i;
            b_r <= opb_i;
            dst_r <= dst_fmt_i;
            rc_r <= rc_i;
            mask_r <= mask_i;
        end
    end

    // Answer registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
            dest_we_o <= 1'b0;
            int_req_o <= 1'b0;
            res_o <= '0;
            mem_o <= 64'h0;
            stat_o <= '{handled: 1'b0, unnormal_res: 1'b0, tag: TAG_EMPTY, cc: CC_EQUAL};
            exc_o <= '0;
            opa_o <= '0;
            opb_o <= '0;
        end else begin
            done_o <= 1'b0;
            dest_we_o <= 1'b0;
            int_req_o <= 1'b0;
            if (state_r == ST_EVAL) begin
                exc_o <= ev_exc;
                opa_o <= ev_opa;
                opb_o <= ev_opb;
                stat_o.cc <= ev_cc;
                stat_o.unnormal_res <= ev_unn & !stop;
                if (stop) begin
                    done_o <= 1'b1;
                    int_req_o <= 1'b1;
                    stat_o.handled <= 1'b1;
                end else if (!ev_den_go) begin
                    done_o <= 1'b1;
                    dest_we_o <= ev_handled & ev_write;
                    res_o <= ev_res;
                    stat_o.handled <= ev_handled;
                    stat_o.tag <= tag_f(ev_res);
                end
            end else if (state_r == ST_DENORM && dn_done) begin
                done_o <= 1'b1;
                dest_we_o <= 1'b1;
                mem_o <= dn_bits;
                stat_o.handled <= 1'b1;
                stat_o.tag <= TAG_SPECIAL;
            end
        end
    end

endmodule
`default_nettype wire

// [testbench/fp_special_sva.sv]
// Port checks for the special operand handler
`timescale 1ns/1ps
`default_nettype none
module fp_special_sva
    import fp_special_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire op_e op_i,
    input wire opnd_s opa_i,
    input wire opnd_s opb_i,
    input wire rnd_e rc_i,
    input wire exc_s mask_i,
    input wire logic done_o,
    input wire logic dest_we_o,
    input wire treal_s res_o,
    input wire stat_s stat_o,
    input wire exc_s exc_o,
    input wire logic int_req_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic busy_r;
    exc_s mask_r;
    logic tk, a_z, b_z, b_dn, a_dn, a_sd, b_nm;
    // Operand classes and request taking
    assign tk = start_i && (!busy_r || done_o);
    assign a_z = opa_i.fmt == FMT_TEMP && opa_i.bits[78:0] == 79'h0;
    assign b_z = opb_i.fmt == FMT_TEMP && opb_i.bits[78:0] == 79'h0;
    assign a_dn = opa_i.fmt == FMT_TEMP && opa_i.bits[78:64] == 15'h0 && |opa_i.bits[63:0];
    assign b_dn = opb_i.fmt == FMT_TEMP && opb_i.bits[78:64] == 15'h0 && |opb_i.bits[63:0];
    assign a_sd = opa_i.fmt == FMT_SHORT && opa_i.bits[30:23] == 8'h0 && |opa_i.bits[22:0];
    assign b_nm = opb_i.fmt == FMT_TEMP && opb_i.bits[63] && opb_i.bits[78:64] != 15'h0;
    // Busy tracking and mask capture
    always_ff @(posedge sys_clk_i) begin
        busy_r <= rst_i ? 1'b0 : (tk || (busy_r && !done_o));
        mask_r <= rst_i ? 3'h0 : (tk ? mask_i : mask_r);
    end
    chk_we_excl: assert property (dest_we_o |-> done_o && !int_req_o) else $error("write with request");
    chk_irq_mask: assert property (done_o |-> int_req_o == |(exc_o & ~mask_r)) else $error("bad request");
    chk_div_indef: assert property (tk && op_i == OP_DIV && b_dn && mask_i.invalid |-> ##2 done_o
        && exc_o.invalid && res_o == {1'b1, EXP_ONES, INDEF_SIG}) else $error("no indefinite");
    chk_zero_sign: assert property (tk && op_i == OP_ADD && a_z && b_z
        && opa_i.bits[79] != opb_i.bits[79] |-> ##2 res_o.sign == ($past(rc_i, 2) == RC_DOWN)
        && stat_o.tag == TAG_ZERO) else $error("zero sign");
    chk_den_flag: assert property (tk && op_i inside {OP_ADD, OP_MUL, OP_COMPARE} && a_dn
        |-> ##2 exc_o.denormal) else $error("no denormal flag");
    chk_load_unn: assert property (tk && op_i == OP_LOAD_REAL && a_sd && mask_i.denormal |-> ##2
        exc_o.denormal && !res_o.sig[63] && stat_o.tag == TAG_VALID) else $error("load not unnormal");
    chk_load_zero: assert property (tk && op_i == OP_LOAD_REAL && a_z |-> ##2 stat_o.tag == TAG_ZERO)
        else $error("zero tag");
    chk_cmp_zero: assert property (tk && op_i == OP_COMPARE && a_z && b_z |-> ##2 stat_o.cc == CC_EQUAL)
        else $error("zeros unequal");
    chk_rem_sign: assert property (tk && op_i == OP_PARTIAL_REMAINDER && a_z && b_nm |-> ##2
        res_o.sign == $past(opa_i.bits[79], 2)) else $error("remainder sign");
endmodule
bind fp_special_handler fp_special_sva u_sva(.sys_clk_i, .rst_i, .start_i, .op_i, .opa_i, .opb_i, .rc_i, .mask_i,
    .done_o, .dest_we_o, .res_o, .stat_o, .exc_o, .int_req_o);
`default_nettype wire

// [testbench/host_issuer.sv]
// Host side issuer of numeric operations
`timescale 1ns/1ps
`default_nettype none
module host_issuer
    import fp_special_pkg::*;
(
    // Clock and answer
    input wire logic sys_clk_i,
    input wire logic done_i,
    // Request
    output logic start_o = 1'b0,
    output op_e op_o = OP_ADD,
    output opnd_s opa_o = '0,
    output opnd_s opb_o = '0
);
    // One request pulse, stale operands spoiled, bounded wait for done
    task automatic issue(input op_e op, input opnd_s a, input opnd_s b, output logic ok);
        @(posedge sys_clk_i);
        #1;
        start_o = 1'b1;
        op_o = op;
        opa_o = a;
        opb_o = b;
        @(posedge sys_clk_i);
        #1;
        start_o = 1'b0;
        opa_o = ~a;
        opb_o = ~b;
        ok = 1'b0;
        repeat (40) begin
            if (!ok) begin
                @(posedge sys_clk_i);
                #1;
                ok = done_i;
            end
        end
    endtask
endmodule
`default_nettype wire

// [testbench/fp_special_handler_bench.sv]
// Self-checking bench for the special operand handler
`timescale 1ns/1ps
`default_nettype none
module fp_special_handler_bench;
    import fp_special_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i, done_o, dest_we_o, int_req_o, ok;
    op_e op_i;
    opnd_s opa_i, opb_i;
    fmt_e dst_fmt_i = FMT_SHORT;
    rnd_e rc_i = RC_NEAREST;
    exc_s mask_i = 3'h7;
    treal_s res_o;
    logic [63:0] mem_o;
    stat_s stat_o;
    exc_s exc_o;
    logic [95:0] r;
    int n_fail = 0;
    int checked = 0;
    int seed = 32'h34B4;
    int cyc = 0;
    localparam opnd_s ONE = {FMT_TEMP, 1'b0, 15'h3FFF, 64'h8000_0000_0000_0000};
    host_issuer u_host(.sys_clk_i, .done_i(done_o), .start_o(start_i), .op_o(op_i), .opa_o(opa_i), .opb_o(opb_i));
    fp_special_handler u_dut(.sys_clk_i, .rst_i, .start_i, .op_i, .opa_i, .opb_i, .dst_fmt_i, .rc_i, .mask_i,
        .done_o, .dest_we_o, .res_o, .mem_o, .stat_o, .exc_o, .int_req_o, .opa_o(), .opb_o());
    // Clock
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // Hang guard
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    function automatic opnd_s tz(input logic s);
        return {FMT_TEMP, s, 79'h0};
    endfunction
    function automatic logic zsign(input rnd_e rc);
        return rc == RC_DOWN;
    endfunction
    task automatic check(input logic c, input string msg);
        checked++;
        if (c !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic run(input op_e op, input opnd_s a, input opnd_s b);
        u_host.issue(op, a, b, ok);
        check(ok, "no done");
    endtask
    task automatic end_sim();
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk_i);
        #1;
        rst_i = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rc_i = rnd_e'(i);
            run(OP_ADD, tz(1'b0), tz(1'b1));
            check(res_o.sign === zsign(rc_i) && stat_o.tag === TAG_ZERO, "zero sum");
        end
        run(OP_COMPARE, tz(1'b0), tz(1'b1));
        check(stat_o.cc === CC_EQUAL, "zero compare");
        run(OP_PARTIAL_REMAINDER, tz(1'b1), ONE);
        check(res_o.sign === 1'b1 && stat_o.tag === TAG_ZERO, "remainder zero");
        run(OP_DIV, ONE, {FMT_TEMP, 80'h1});
        check(res_o === {1'b1, EXP_ONES, INDEF_SIG} && exc_o.invalid === 1'b1, "divisor");
        mask_i = 3'h5;
        run(OP_DIV, ONE, {FMT_TEMP, 80'h1});
        check(int_req_o === 1'b1 && dest_we_o === 1'b0, "unmasked");
        mask_i = 3'h7;
        run(OP_LOAD_REAL, {FMT_SHORT, 80'h1}, ONE);
        check(exc_o.denormal === 1'b1 && !res_o.sig[63] && stat_o.tag === TAG_VALID, "load");
        run(OP_STORE_REAL, {FMT_TEMP, 1'b0, 15'h3F80, ONE.bits[63:0]}, ONE);
        check(mem_o[31:0] === 32'h0040_0000 && stat_o.tag === TAG_SPECIAL, "store");
        run(OP_LOAD_REAL, tz(1'b1), ONE);
        // Random traffic for the checker
        repeat (200) begin
            r = {$random(seed), $random(seed), $random(seed)};
            mask_i = r[2:0];
            rc_i = rnd_e'(r[4:3]);
            run(r[5] ? OP_MUL : OP_COMPARE, {FMT_TEMP, r[95:16] >> r[15:9]}, {FMT_TEMP, r[79:0]});
        end
        end_sim();
    end
endmodule
`default_nettype wire
